// *** logic/xcs_pkg.sv ***
`default_nettype none
package xcs_pkg;
  // Fixed I/O port decodes
  localparam logic [15:0] KBD_PORT_DATA = 16'h0060;
  localparam logic [15:0] KBD_PORT_CMD = 16'h0064;
  localparam logic [15:0] MICRO_PORT_DATA = 16'h0062;
  localparam logic [15:0] MICRO_PORT_CMD = 16'h0066;
  localparam logic [15:0] CLOCK_PORT_ADDR = 16'h0070;
  localparam logic [15:0] CLOCK_PORT_DATA = 16'h0071;
  // Clock chip strobe length in SYSCLK periods
  localparam int unsigned STROBE_SYSCLKS = 2;
  localparam logic [1:0] STROBE_COUNT = 2'h2;
  // Processor init pulse length in system clocks
  localparam logic [6:0] INIT_PULSE_CYCLES = 7'h40;
  // Register indices on the plain register port
  localparam logic [3:0] REG_DECODE_EN = 4'h0;
  localparam logic [3:0] REG_GPO_SEL = 4'h1;
  localparam logic [3:0] REG_GPO_VAL = 4'h2;
  localparam logic [3:0] REG_RANGE0_BASE = 4'h3;
  localparam logic [3:0] REG_RANGE0_MASK = 4'h4;
  localparam logic [3:0] REG_RANGE1_BASE = 4'h5;
  localparam logic [3:0] REG_RANGE1_MASK = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  // Decode enable bit positions
  localparam int EN_BOOT = 0;
  localparam int EN_KBD = 1;
  localparam int EN_CLOCK = 2;
  localparam int EN_MICRO = 3;
  localparam int EN_RANGE0 = 4;
  localparam int EN_RANGE1 = 5;
  // General output bit positions
  localparam int GPO_KBD = 0;
  localparam int GPO_STROBE = 1;
  localparam int GPO_CLOCK = 2;
  localparam int GPO_DIR = 3;
  localparam int GPO_OE = 4;
  // Reset values
  localparam logic [5:0] DECODE_EN_RESET = 6'h0f;
  localparam logic [4:0] GPO_SEL_RESET = 5'h00;
  localparam logic [4:0] GPO_VAL_RESET = 5'h1b;
  localparam logic [15:0] RANGE_RESET = 16'h0000;
  localparam logic [23:0] BOOT_BASE_DEFAULT = 24'h0e0000;
  localparam logic [23:0] BOOT_MASK_DEFAULT = 24'hfe0000;
endpackage
`default_nettype wire

// *** logic/xcs_sync3.sv ***
`default_nettype none
module xcs_sync3 import xcs_pkg::*; #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_level,
  output logic o_fall,
  output logic o_rise
);
  logic s1;
  logic s2;
  logic s3;
  // Three stage sampler; change counts once stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
  // Edges of the filtered level
  assign o_fall = o_level && (s2 == s3) && !s3;
  assign o_rise = !o_level && (s2 == s3) && s3;
endmodule
`default_nettype wire

// *** logic/xcs_range_match.sv ***
`default_nettype none
module xcs_range_match import xcs_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] i_addr,
  input wire logic [WIDTH-1:0] i_base,
  input wire logic [WIDTH-1:0] i_mask,
  output logic o_hit
);
  // Masked compare; mask bits set take part in the match
  assign o_hit = ((i_addr ^ i_base) & i_mask) == '0;
endmodule
`default_nettype wire

// *** logic/xcs_decoder.sv ***
// The address map and strobed register access were left to the implementer.
`default_nettype none
module xcs_decoder import xcs_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [19:0] i_sys_addr,
  input wire logic [23:17] i_lat_addr,
  input wire logic i_io_read_n,
  input wire logic i_io_write_n,
  input wire logic i_mem_read_n,
  input wire logic i_mem_write_n,
  input wire logic i_isa_master,
  input wire logic i_dma_active,
  input wire logic i_dma_grant_n,
  input wire logic i_dma_read,
  input wire logic i_apic_hit,
  input wire logic i_sysclk,
  input wire logic i_kbd_reset_request_n,
  input wire logic [3:0] i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [23:0] o_reg_rdata,
  output logic o_kbd_ctrl_select_n,
  output logic o_micro_ctrl_select_n,
  output logic o_prog_range0_select_n,
  output logic o_prog_range1_select_n,
  output logic o_boot_rom_select_n,
  output logic o_clock_chip_select_n,
  output logic o_clock_chip_addr_strobe,
  output logic o_xbuf_direction_n,
  output logic o_xbuf_output_enable_n,
  output logic o_cpu_init
);
  logic [5:0] decode_en;
  logic [4:0] gpo_sel;
  logic [4:0] gpo_val;
  logic [15:0] range0_base;
  logic [15:0] range0_mask;
  logic [15:0] range1_base;
  logic [15:0] range1_mask;
  logic io_cmd;
  logic io_hit_kbd;
  logic io_hit_micro;
  logic io_hit_clock;
  logic range0_hit;
  logic range1_hit;
  logic range0_sel;
  logic range1_sel;
  logic boot_hit;
  logic boot_sel;
  logic fixed_sel;
  logic iow_fall;
  logic iow_level;
  logic sysclk_rise;
  logic sysclk_level;
  logic kbd_reset_request_n_fall;
  logic kbd_reset_request_n_level;
  logic [1:0] strobe_cnt;
  logic strobe;
  logic [6:0] init_cnt;
  logic oe_isa_hold;
  logic oe_func_n;
  logic dir_func_n;
  logic isa_cmd;
  logic oe_decode;
  logic [23:0] full_addr;
  logic port_kbd;
  logic port_micro;
  logic port_clock;
  logic isa_addr_match;
  logic [4:0] pin_func;
  logic [4:0] pin_out;

  // Synchronised copies of pins from other timing domains
  xcs_sync3 #(.RESET_VAL(1'b1)) u_sync_iow (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_io_write_n),
    .o_level(iow_level),
    .o_fall(iow_fall),
    .o_rise()
  );
  xcs_sync3 #(.RESET_VAL(1'b0)) u_sync_sysclk (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_sysclk),
    .o_level(sysclk_level),
    .o_fall(),
    .o_rise(sysclk_rise)
  );
  xcs_sync3 #(.RESET_VAL(1'b1)) u_sync_kbd_reset_request_n (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_kbd_reset_request_n),
    .o_level(kbd_reset_request_n_level),
    .o_fall(kbd_reset_request_n_fall),
    .o_rise()
  );

  // Fixed I/O decodes; I/O uses only the low sixteen address lines
  assign full_addr = {i_lat_addr, i_sys_addr[16:0]};
  assign io_cmd = !i_io_read_n || !i_io_write_n;
  assign port_kbd = i_sys_addr[15:0] == KBD_PORT_DATA ||
                    i_sys_addr[15:0] == KBD_PORT_CMD;
  assign port_micro = i_sys_addr[15:0] == MICRO_PORT_DATA ||
                      i_sys_addr[15:0] == MICRO_PORT_CMD;
  assign port_clock = i_sys_addr[15:0] == CLOCK_PORT_DATA;
  assign io_hit_kbd = io_cmd && port_kbd;
  assign io_hit_micro = io_cmd && port_micro;
  assign io_hit_clock = io_cmd && port_clock;

  // Programmable I/O ranges, PCI-master cycles only
  xcs_range_match #(.WIDTH(16)) u_range0 (
    .i_addr(i_sys_addr[15:0]),
    .i_base(range0_base),
    .i_mask(range0_mask),
    .o_hit(range0_hit)
  );
  xcs_range_match #(.WIDTH(16)) u_range1 (
    .i_addr(i_sys_addr[15:0]),
    .i_base(range1_base),
    .i_mask(range1_mask),
    .o_hit(range1_hit)
  );
  assign range0_sel = io_cmd && !i_isa_master && !i_dma_active &&
                      decode_en[EN_RANGE0] && range0_hit;
  assign range1_sel = io_cmd && !i_isa_master && !i_dma_active &&
                      decode_en[EN_RANGE1] && range1_hit;

  // Boot ROM memory window decode
  xcs_range_match #(.WIDTH(24)) u_boot (
    .i_addr(full_addr),
    .i_base(BOOT_BASE_DEFAULT),
    .i_mask(BOOT_MASK_DEFAULT),
    .o_hit(boot_hit)
  );
  assign boot_sel = boot_hit && decode_en[EN_BOOT] && !i_dma_active &&
                    (!i_mem_read_n || !i_mem_write_n);

  // Any enabled X-Bus device decoded
  assign fixed_sel = (io_hit_kbd && decode_en[EN_KBD]) ||
                     (io_hit_micro && decode_en[EN_MICRO]) ||
                     (io_hit_clock && decode_en[EN_CLOCK]);
  assign oe_decode = fixed_sel || boot_sel || range0_sel || range1_sel;
  assign isa_cmd = !i_io_read_n || !i_io_write_n || !i_mem_read_n || !i_mem_write_n;

  // Address-only decode; keeps an ISA-master enable alive after its command ends
  assign isa_addr_match = (port_kbd && decode_en[EN_KBD]) ||
                          (port_micro && decode_en[EN_MICRO]) ||
                          (port_clock && decode_en[EN_CLOCK]) ||
                          (boot_hit && decode_en[EN_BOOT]);

  // ISA-master enable holds until the address no longer decodes
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      oe_isa_hold <= 1'b0;
    end else if (!i_isa_master) begin
      oe_isa_hold <= 1'b0;
    end else if (isa_cmd && oe_decode) begin
      oe_isa_hold <= 1'b1;
    end else if (!isa_addr_match) begin
      oe_isa_hold <= 1'b0;
    end
  end
  // Output enable follows command for PCI master, address for ISA master
  assign oe_func_n = !((isa_cmd && oe_decode) ||
                       (i_isa_master && oe_isa_hold && isa_addr_match));

  // Direction: I/O reads, boot or APIC memory reads, DMA reads from X-Bus
  always_comb begin
    dir_func_n = 1'b1;
    if (!i_io_read_n) begin
      dir_func_n = 1'b0;
    end else if (!i_mem_read_n && !i_dma_active && boot_hit && decode_en[EN_BOOT]) begin
      dir_func_n = 1'b0;
    end else if (!i_mem_read_n && !i_dma_active && !i_isa_master && i_apic_hit) begin
      dir_func_n = 1'b0;
    end else if (!i_dma_grant_n && i_dma_read) begin
      dir_func_n = 1'b0;
    end
    if (range0_sel || range1_sel) begin
      dir_func_n = i_io_read_n;
    end
  end

  // Clock chip address strobe: from write fall to 70h for two SYSCLKs
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      strobe_cnt <= 2'h0;
      strobe <= 1'b0;
    end else if (iow_fall && i_sys_addr[15:0] == CLOCK_PORT_ADDR) begin
      strobe_cnt <= STROBE_COUNT;
      strobe <= 1'b1;
    end else if (strobe && sysclk_rise) begin
      if (strobe_cnt == 2'h1) begin
        strobe <= 1'b0;
      end
      strobe_cnt <= strobe_cnt - 2'h1;
    end
  end

  // Processor init pulse from keyboard reset request
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      init_cnt <= 7'h00;
    end else if (kbd_reset_request_n_fall) begin
      init_cnt <= INIT_PULSE_CYCLES;
    end else if (init_cnt != 7'h00) begin
      init_cnt <= init_cnt - 7'h01;
    end
  end
  assign o_cpu_init = init_cnt != 7'h00;

  // Per-pin general output override; bit order follows the general output positions
  assign pin_func = {oe_func_n, dir_func_n, !(io_hit_clock && decode_en[EN_CLOCK]),
                     strobe, !(io_hit_kbd && decode_en[EN_KBD])};
  generate
    for (genvar g = 0; g < 5; g++) begin : g_gpo
      assign pin_out[g] = gpo_sel[g] ? gpo_val[g] : pin_func[g];
    end
  endgenerate

  // Pin outputs, general-output override on the five general output pins only; held inactive in reset
  always_comb begin
    if (i_sys_rst) begin
      o_kbd_ctrl_select_n = 1'b1;
      o_clock_chip_select_n = 1'b1;
      o_clock_chip_addr_strobe = 1'b0;
      o_xbuf_direction_n = 1'b1;
      o_xbuf_output_enable_n = 1'b1;
      o_micro_ctrl_select_n = 1'b1;
      o_prog_range0_select_n = 1'b1;
      o_prog_range1_select_n = 1'b1;
      o_boot_rom_select_n = 1'b1;
    end else begin
      o_kbd_ctrl_select_n = pin_out[GPO_KBD];
      o_clock_chip_select_n = pin_out[GPO_CLOCK];
      o_clock_chip_addr_strobe = pin_out[GPO_STROBE];
      o_xbuf_direction_n = pin_out[GPO_DIR];
      o_xbuf_output_enable_n = pin_out[GPO_OE];
      o_micro_ctrl_select_n = !(io_hit_micro && decode_en[EN_MICRO]);
      o_prog_range0_select_n = !range0_sel;
      o_prog_range1_select_n = !range1_sel;
      o_boot_rom_select_n = !boot_sel;
    end
  end

  // Decode enable register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      decode_en <= DECODE_EN_RESET;
    end else if (i_reg_write && i_reg_addr == REG_DECODE_EN) begin
      decode_en <= i_reg_wdata[5:0];
    end
  end

  // General output select register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      gpo_sel <= GPO_SEL_RESET;
    end else if (i_reg_write && i_reg_addr == REG_GPO_SEL) begin
      gpo_sel <= i_reg_wdata[4:0];
    end
  end

  // General output value register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      gpo_val <= GPO_VAL_RESET;
    end else if (i_reg_write && i_reg_addr == REG_GPO_VAL) begin
      gpo_val <= i_reg_wdata[4:0];
    end
  end

  // Programmable range 0 base and mask
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      range0_base <= RANGE_RESET;
      range0_mask <= RANGE_RESET;
    end else if (i_reg_write && i_reg_addr == REG_RANGE0_BASE) begin
      range0_base <= i_reg_wdata[15:0];
    end else if (i_reg_write && i_reg_addr == REG_RANGE0_MASK) begin
      range0_mask <= i_reg_wdata[15:0];
    end
  end

  // Programmable range 1 base and mask
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      range1_base <= RANGE_RESET;
      range1_mask <= RANGE_RESET;
    end else if (i_reg_write && i_reg_addr == REG_RANGE1_BASE) begin
      range1_base <= i_reg_wdata[15:0];
    end else if (i_reg_write && i_reg_addr == REG_RANGE1_MASK) begin
      range1_mask <= i_reg_wdata[15:0];
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 24'h000000;
    end else if (i_reg_read) begin
      case (i_reg_addr)
        REG_DECODE_EN: o_reg_rdata <= {18'h00000, decode_en};
        REG_GPO_SEL: o_reg_rdata <= {19'h00000, gpo_sel};
        REG_GPO_VAL: o_reg_rdata <= {19'h00000, gpo_val};
        REG_RANGE0_BASE: o_reg_rdata <= {8'h00, range0_base};
        REG_RANGE0_MASK: o_reg_rdata <= {8'h00, range0_mask};
        REG_RANGE1_BASE: o_reg_rdata <= {8'h00, range1_base};
        REG_RANGE1_MASK: o_reg_rdata <= {8'h00, range1_mask};
        REG_STATUS: o_reg_rdata <= {18'h00000, sysclk_level, kbd_reset_request_n_level,
                                    iow_level, o_cpu_init, strobe, oe_isa_hold};
        default: o_reg_rdata <= 24'h000000;
      endcase
    end else begin
      o_reg_rdata <= 24'h000000;
    end
  end
endmodule
`default_nettype wire

// *** test/xcs_decoder_sva.sv ***
`default_nettype none
module xcs_decoder_sva import xcs_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [19:0] i_sys_addr,
  input wire logic i_io_read_n,
  input wire logic i_io_write_n,
  input wire logic i_mem_read_n,
  input wire logic i_isa_master,
  input wire logic i_dma_active,
  input wire logic i_dma_grant_n,
  input wire logic [3:0] i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic o_kbd_ctrl_select_n,
  input wire logic o_micro_ctrl_select_n,
  input wire logic o_prog_range0_select_n,
  input wire logic o_prog_range1_select_n,
  input wire logic o_boot_rom_select_n,
  input wire logic o_clock_chip_select_n,
  input wire logic o_clock_chip_addr_strobe,
  input wire logic o_xbuf_direction_n,
  input wire logic o_xbuf_output_enable_n,
  input wire logic o_cpu_init
);
  logic [5:0] en;
  logic [4:0] gs;
  logic io_cmd;
  logic [15:0] a;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Command and port terms
  assign io_cmd = !i_io_read_n || !i_io_write_n;
  assign a = i_sys_addr[15:0];
  // Shadow of decode enables and general output selects
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      en <= DECODE_EN_RESET;
      gs <= GPO_SEL_RESET;
    end else if (i_reg_write && i_reg_addr == REG_DECODE_EN) begin
      en <= i_reg_wdata[5:0];
    end else if (i_reg_write && i_reg_addr == REG_GPO_SEL) begin
      gs <= i_reg_wdata[4:0];
    end
  end
  a_kbd_select: assert property (
    !gs[GPO_KBD] |-> o_kbd_ctrl_select_n ==
    !(en[EN_KBD] && io_cmd && (a == KBD_PORT_DATA || a == KBD_PORT_CMD)))
    else $error("keyboard select wrong");
  a_micro_select: assert property (
    o_micro_ctrl_select_n ==
    !(en[EN_MICRO] && io_cmd && (a == MICRO_PORT_DATA || a == MICRO_PORT_CMD)))
    else $error("micro select wrong");
  a_clock_select: assert property (
    !gs[GPO_CLOCK] |-> o_clock_chip_select_n == !(en[EN_CLOCK] && io_cmd && a == CLOCK_PORT_DATA))
    else $error("clock chip select wrong");
  a_boot_no_dma: assert property (i_dma_active |-> o_boot_rom_select_n)
    else $error("boot select during dma");
  a_range_owner: assert property (
    i_isa_master || i_dma_active |-> o_prog_range0_select_n && o_prog_range1_select_n)
    else $error("range select for wrong owner");
  a_range_buffer: assert property (
    !gs[GPO_OE] && !(o_prog_range0_select_n && o_prog_range1_select_n)
    |-> !o_xbuf_output_enable_n)
    else $error("range select without buffer");
  a_dir_io_read: assert property (!gs[GPO_DIR] && !i_io_read_n |-> !o_xbuf_direction_n)
    else $error("direction high on io read");
  a_dir_idle_high: assert property (
    !gs[GPO_DIR] && i_io_read_n && i_mem_read_n && i_dma_grant_n |-> o_xbuf_direction_n)
    else $error("direction low while idle");
  a_oe_disabled: assert property (
    !gs[GPO_OE] && io_cmd && a == KBD_PORT_DATA && !en[EN_KBD] && !en[EN_RANGE0]
    && !en[EN_RANGE1] |-> o_xbuf_output_enable_n)
    else $error("buffer enabled for disabled decode");
  a_strobe_len: assert property (
    $rose(o_clock_chip_addr_strobe) && !gs[GPO_STROBE]
    |-> o_clock_chip_addr_strobe [*4] ##[1:5] !o_clock_chip_addr_strobe)
    else $error("strobe length wrong");
  a_init_pulse: assert property ($rose(o_cpu_init) |-> ##63 o_cpu_init ##1 !o_cpu_init)
    else $error("init pulse length wrong");
  a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |->
    o_kbd_ctrl_select_n && o_micro_ctrl_select_n && o_clock_chip_select_n &&
    o_xbuf_direction_n && o_xbuf_output_enable_n && !o_clock_chip_addr_strobe)
    else $error("outputs active in reset");
  c_kbd: cover property (!o_kbd_ctrl_select_n);
  c_strobe: cover property ($rose(o_clock_chip_addr_strobe));
  c_init: cover property ($rose(o_cpu_init));
endmodule
bind xcs_decoder xcs_decoder_sva u_sva (.*);
`default_nettype wire

// *** test/xcs_xbus_model.sv ***
`default_nettype none
module xcs_xbus_model (
  input wire logic i_clock_chip_select_n,
  input wire logic i_io_read_n,
  input wire logic i_io_write_n,
  input wire logic i_xbuf_direction_n,
  input wire logic i_xbuf_output_enable_n,
  output logic o_clock_read_n,
  output logic o_clock_write_n,
  output logic [7:0] o_xdata
);
  // Two OR gates split the clock chip select into read and write commands
  assign o_clock_read_n = i_clock_chip_select_n | i_io_read_n;
  assign o_clock_write_n = i_clock_chip_select_n | i_io_write_n;
  // Peripheral data reaches the system side only on an enabled read path
  assign o_xdata = (!i_xbuf_direction_n && !i_xbuf_output_enable_n) ? 8'h5a : 8'ha5;
endmodule
`default_nettype wire

// *** test/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xcs_pkg::*;
  typedef struct packed {
    logic [2:0] m;
    logic [2:0] c;
    logic [19:0] a;
    logic [6:0] l;
    logic [5:0] e;
  } xcs_row_s;
  logic i_clk_sys, i_sys_rst, i_io_read_n, i_io_write_n, i_mem_read_n, i_mem_write_n;
  logic i_isa_master, i_dma_active, i_dma_grant_n, i_dma_read, i_apic_hit, i_sysclk;
  logic i_kbd_reset_request_n, i_reg_write, i_reg_read, clk_rd_n, clk_wr_n;
  logic [19:0] i_sys_addr;
  logic [23:17] i_lat_addr;
  logic [3:0] i_reg_addr, rng;
  logic [23:0] i_reg_wdata, o_reg_rdata, d;
  logic o_kbd_ctrl_select_n, o_micro_ctrl_select_n, o_prog_range0_select_n;
  logic o_prog_range1_select_n, o_boot_rom_select_n, o_clock_chip_select_n;
  logic o_clock_chip_addr_strobe, o_xbuf_direction_n, o_xbuf_output_enable_n, o_cpu_init;
  logic [5:0] sel;
  logic [7:0] xdata;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  // Rows: owner {isa,apic,dma}, command {memrd,iowr,iord}, address, expected selects
  xcs_row_s rows [11] = '{'{0, 1, 'h60, 0, 'h1c}, '{0, 2, 'h64, 0, 'h1e},
    '{0, 1, 'h62, 0, 'h2c}, '{0, 2, 'h66, 0, 'h2e}, '{0, 1, 'h71, 0, 'h34},
    '{0, 2, 'h71, 0, 'h36}, '{0, 4, 'he0000, 7, 'h38}, '{0, 1, 'h80, 0, 'h3d},
    '{0, 4, 'h10000, 0, 'h3f}, '{0, 2, 'h61, 0, 'h3f}, '{4, 4, 'he0000, 7, 'h38}};
  assign sel = {o_kbd_ctrl_select_n, o_micro_ctrl_select_n, o_clock_chip_select_n,
    o_boot_rom_select_n, o_xbuf_direction_n, o_xbuf_output_enable_n};
  assign rng = {o_prog_range0_select_n, o_prog_range1_select_n, sel[1:0]};
  xcs_decoder u_dut (.*);
  xcs_xbus_model u_xbus (.i_clock_chip_select_n(o_clock_chip_select_n),
    .i_io_read_n(i_io_read_n), .i_io_write_n(i_io_write_n),
    .i_xbuf_direction_n(o_xbuf_direction_n), .i_xbuf_output_enable_n(o_xbuf_output_enable_n),
    .o_clock_read_n(clk_rd_n), .o_clock_write_n(clk_wr_n), .o_xdata(xdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_sysclk = 1'b0;
    forever #40 i_sysclk = ~i_sysclk;
  end
  task chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic [2:0] m, input logic [2:0] c, input logic [19:0] a, input logic [6:0] l);
    @(posedge i_clk_sys);
    {i_isa_master, i_apic_hit, i_dma_active} <= m;
    {i_dma_read, i_dma_grant_n} <= {m[0], !m[0]};
    {i_mem_read_n, i_io_write_n, i_io_read_n} <= ~c;
    i_sys_addr <= a;
    i_lat_addr <= l;
    @(negedge i_clk_sys);
  endtask
  task wreg(input logic [3:0] a, input logic [23:0] v);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_write <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_write <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, output logic [23:0] v);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_read <= 1'b0;
    @(negedge i_clk_sys);
    v = o_reg_rdata;
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #50us;
    miscompares++;
    end_sim;
  end
  initial begin
    {i_sys_rst, i_mem_write_n, i_kbd_reset_request_n, i_dma_grant_n} = 4'hf;
    {i_io_read_n, i_io_write_n, i_mem_read_n} = 3'h7;
    {i_isa_master, i_dma_active, i_dma_read, i_apic_hit, i_reg_write, i_reg_read} = 6'h0;
    {i_sys_addr, i_lat_addr, i_reg_addr, i_reg_wdata} = '0;
    // Decodable command under reset leaves every output idle
    bus(3'h0, 3'h1, 20'h60, 7'h0);
    chk({sel, o_clock_chip_addr_strobe}, 7'h7e, "reset");
    // Bus idles before release so no command straddles the reset edge
    bus(3'h0, 3'h0, 20'h0, 7'h0);
    repeat (8) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      bus(rows[i].m, rows[i].c, rows[i].a, rows[i].l);
      chk(sel, rows[i].e, "selects");
      chk({clk_rd_n, clk_wr_n}, {!(rows[i].c == 1 && rows[i].a == 'h71),
        !(rows[i].c == 2 && rows[i].a == 'h71)}, "clock cmds");
    end
    $display("test rows done");
    // Direction on APIC, DMA and idle cycles
    bus(3'h2, 3'h4, 20'h10000, 7'h0);
    chk(o_xbuf_direction_n, 1'b0, "apic pci");
    bus(3'h6, 3'h4, 20'h10000, 7'h0);
    chk(o_xbuf_direction_n, 1'b1, "apic isa");
    bus(3'h1, 3'h4, 20'he0000, 7'h7);
    chk({o_boot_rom_select_n, o_xbuf_direction_n}, 2'h2, "dma");
    bus(3'h0, 3'h0, 20'h0, 7'h0);
    chk(o_xbuf_direction_n, 1'b1, "idle");
    // ISA-master enable outlives the command while the boot address stands
    bus(3'h4, 3'h4, 20'he0000, 7'h7);
    bus(3'h4, 3'h0, 20'he0000, 7'h7);
    chk(o_xbuf_output_enable_n, 1'b0, "isa oe hold");
    bus(3'h4, 3'h0, 20'h0, 7'h0);
    chk(o_xbuf_output_enable_n, 1'b1, "isa oe release");
    $display("test direction done");
    // Registers, disabled decode and programmable range
    rreg(REG_DECODE_EN, d);
    chk(d, {18'h0, DECODE_EN_RESET}, "enable reset");
    rreg(4'hf, d);
    chk(d, 24'h0, "unmapped");
    wreg(REG_DECODE_EN, 24'hd);
    rreg(REG_DECODE_EN, d);
    chk(d, 24'hd, "enable");
    bus(3'h0, 3'h1, 20'h60, 7'h0);
    chk(sel, 6'h3d, "kbd off");
    wreg(REG_RANGE0_BASE, 24'h300);
    wreg(REG_RANGE0_MASK, 24'hfff0);
    wreg(REG_DECODE_EN, 24'h1f);
    bus(3'h0, 3'h1, 20'h305, 7'h0);
    chk(rng, 4'h4, "range hit");
    bus(3'h0, 3'h1, 20'h315, 7'h0);
    chk(rng, 4'hd, "range miss");
    bus(3'h4, 3'h1, 20'h305, 7'h0);
    chk(rng[3], 1'b1, "range isa");
    bus(3'h0, 3'h0, 20'h0, 7'h0);
    wreg(REG_GPO_SEL, 24'h4);
    @(negedge i_clk_sys);
    chk(o_clock_chip_select_n, 1'b0, "general output");
    wreg(REG_GPO_SEL, 24'h0);
    $display("test registers done");
    // Clock chip address strobe after a write to the address port
    // Write command held long enough to pass the three-stage pin sampler
    bus(3'h0, 3'h2, 20'h70, 7'h0);
    repeat (4) @(posedge i_clk_sys);
    bus(3'h0, 3'h0, 20'h70, 7'h0);
    n = 0;
    while (!o_clock_chip_addr_strobe && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    n = 0;
    while (o_clock_chip_addr_strobe && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk({23'h0, n >= 4 && n <= 9}, 24'h1, "strobe length");
    // Keyboard reset request gives one init pulse
    @(posedge i_clk_sys);
    i_kbd_reset_request_n <= 1'b0;
    n = 0;
    repeat (100) begin
      @(negedge i_clk_sys);
      n += int'(o_cpu_init === 1'b1);
    end
    chk(24'(n), 24'd64, "init length");
    $display("test strobe and init done");
    // Reset in mid-run idles every output during a decodable command
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    i_kbd_reset_request_n <= 1'b1;
    bus(3'h0, 3'h1, 20'h64, 7'h0);
    chk({sel, o_clock_chip_addr_strobe, o_cpu_init}, 8'hfc, "reset mid-run");
    bus(3'h0, 3'h0, 20'h0, 7'h0);
    repeat (8) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    bus(3'h0, 3'h1, 20'h64, 7'h0);
    chk(sel, 6'h1c, "after reset");
    $display("test mid-run reset done");
    end_sim;
  end
endmodule
`default_nettype wire
